// *** dv/ecs_phy_model.sv ***
`timescale 1ns/1ps
// PHY side model: drives the mode pins from its own link clock.
module ecs_phy_model (
  input wire logic [2:0] pin_req,
  output logic ext_speed_in,
  output logic ext_duplex_in,
  output logic short_gap_in
);
  // Link clock at one eighth of the block clock, rising on its falling edges.
  logic link_clk = 1'b0;
  always #100 link_clk = ~link_clk;
  // Pins start low, then follow the request on a link edge.
  initial {ext_speed_in, ext_duplex_in, short_gap_in} = 3'h0;
  always @(posedge link_clk) begin
    {ext_speed_in, ext_duplex_in, short_gap_in} <= pin_req;
  end
endmodule

// *** dv/ethernet_mac_control_status_tb_top.sv ***
`timescale 1ns/1ps
module ethernet_mac_control_status_tb_top;
  import ecs_pkg::*;
  // Every input starts at a known level.
  logic sys_clk = 1'b0, srst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [AXI_DW-1:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic rx_frame_done = 1'b0, rx_frame_err = 1'b0, rx_frame_ctrl = 1'b0;
  logic rx_frame_pause = 1'b0, pause_quantum_tick = 1'b0, rx_flow_trigger = 1'b0;
  logic tx_busy = 1'b0, tx_good_done = 1'b0, tx_coll_defer = 1'b0;
  logic [FLEN_W-1:0] rx_frame_len = 16'h0;
  logic [PQ_W-1:0] rx_pause_quanta = 16'h0003;
  logic [2:0] pins = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [AXI_DW-1:0] s_axi_rdata;
  logic ext_speed_in, ext_duplex_in, short_gap_in;
  logic rx_keep_r, rx_drop_r, rx_desc_ctrl_r, rx_desc_frag_r, rx_desc_under_r;
  logic rx_desc_over_r, rx_desc_jabber_r, rx_desc_err_r, rx_ctrl_act_r;
  logic gig_mode_r, duplex_mode_r, duplex_out_r, interface_control_out_a_r;
  logic interface_control_out_b_r, tx_short_gap_r, iface_reset_r, test_write_en_r;
  logic loopback_r, force_coll_r, send_pause_r, tx_hold_new_r, mac_idle_r;
  logic [2:0] tx_ipg_count_r;
  // Expectations waiting for the monitor, oldest first.
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [8:0] fq[$];
  logic [33:0] re;
  logic [8:0] fe, fo;
  logic [31:0] rs = 32'h0000_004E, c;
  logic [15:0] n;
  logic [2:0] f;
  logic [15:0] lens [4] = '{16'h003F, 16'h0040, 16'h0064, 16'h0065};
  int miscompares = 0, checked = 0;

  ecs_mac_ctrl ecs_mac_ctrl_inst (
    .sys_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .ext_speed_in, .ext_duplex_in, .short_gap_in,
    .rx_frame_done, .rx_frame_len, .rx_frame_err, .rx_frame_ctrl, .rx_frame_pause,
    .rx_pause_quanta, .pause_quantum_tick, .rx_flow_trigger, .tx_busy, .tx_good_done,
    .tx_coll_defer, .rx_keep_r, .rx_drop_r, .rx_desc_ctrl_r, .rx_desc_frag_r,
    .rx_desc_under_r, .rx_desc_over_r, .rx_desc_jabber_r, .rx_desc_err_r, .rx_ctrl_act_r,
    .gig_mode_r, .duplex_mode_r, .duplex_out_r, .interface_control_out_a_r,
    .interface_control_out_b_r, .tx_short_gap_r, .iface_reset_r, .test_write_en_r,
    .loopback_r, .force_coll_r, .send_pause_r, .tx_hold_new_r, .tx_ipg_count_r, .mac_idle_r
  );
  ecs_phy_model ecs_phy_model_inst (
    .pin_req(pins), .ext_speed_in, .ext_duplex_in, .short_gap_in
  );

  // Block clock at 40 MHz.
  always #12.5 sys_clk = ~sys_clk;

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected filter verdict; f is error, control, pause.
  function automatic logic [8:0] fx(input logic [15:0] l, input logic [2:0] g,
      input logic [31:0] k);
    logic s, lg, kp;
    s = l < MIN_FRAME_LEN;
    lg = l > 16'h0064;
    kp = !((g[1] & !k[CB_COPY_CTRL]) | (s & !k[CB_COPY_SHORT]) | (g[2] & !k[CB_COPY_ERR]));
    return {kp, !kp, g[1] & !g[0], g[1], s & g[2], s & !g[2], lg & !g[2], lg & g[2], g[2]};
  endfunction

  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge sys_clk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge sys_clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask

  // One frame event; an all-zero expectation means the block must stay silent.
  task automatic fr(input logic [15:0] l, input logic [2:0] g, input logic [8:0] x);
    @(posedge sys_clk);
    if (x != 9'h0) fq.push_back(x);
    rx_frame_len <= l;
    {rx_frame_err, rx_frame_ctrl, rx_frame_pause} <= g;
    rx_frame_done <= 1'b1;
    @(posedge sys_clk);
    rx_frame_done <= 1'b0;
  endtask

  // Mode levels and status, worked out from the control word and the pins.
  task automatic lv(input logic [31:0] k);
    logic g, d, a;
    g = (k[18] ? pins[2] : k[7]) | k[17];
    d = (k[18] ? pins[1] : k[0]) | g | k[1];
    a = k[3] & rx_flow_trigger;
    cmp("levels", {20'h0, g, d, k[0], k[15], k[16], k[10] & pins[0], !k[5], k[2], k[1],
        a & !d, a & d, k[11] & !tx_busy}, {20'h0, gig_mode_r, duplex_mode_r,
        duplex_out_r, interface_control_out_a_r, interface_control_out_b_r, tx_short_gap_r,
        iface_reset_r, test_write_en_r, loopback_r, force_coll_r, send_pause_r,
        mac_idle_r});
    rd(OFS_STATUS, {k[11] & !tx_busy, 26'h0, pins[2:1], 1'b0, a, 1'b0}, RESP_OKAY);
    rd(OFS_CONTROL, k & CONTROL_MASK, RESP_OKAY);
  endtask

  // Monitor: each result that appears takes the oldest expectation.
  always @(posedge sys_clk) begin
    fo = {rx_keep_r, rx_drop_r, rx_ctrl_act_r, rx_desc_ctrl_r, rx_desc_frag_r,
        rx_desc_under_r, rx_desc_over_r, rx_desc_jabber_r, rx_desc_err_r};
    if (s_axi_bvalid && s_axi_bready) begin
      cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      cmp("rdata", re[31:0], s_axi_rdata);
      cmp("rresp", {30'h0, re[33:32]}, {30'h0, s_axi_rresp});
    end
    if (rx_keep_r || rx_drop_r) begin
      fe = (fq.size() != 0) ? fq.pop_front() : 9'h1FF;
      // Descriptor flags only matter for frames that are kept.
      cmp("frame", {23'h0, fe & (fe[8] ? 9'h1FF : 9'h1C0)},
          {23'h0, fo & (fe[8] ? 9'h1FF : 9'h1C0)});
    end
  end

  // Watchdog sized well above the expected run of about a thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR watchdog expired");
    end_sim();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(OFS_CONTROL, CONTROL_RESET, RESP_OKAY);
    rd(OFS_MAX_LEN, {21'h0, MAXLEN_RESET}, RESP_OKAY);
    wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    wr(OFS_MAX_LEN, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_MAX_LEN, 32'h0000_07FF, RESP_OKAY);
    wr(OFS_MAX_LEN, 32'h0000_0064, RESP_OKAY);
    fr(16'h0064, 3'h0, 9'h0);
    // Loopback is only changed while the interface is disabled.
    wr(OFS_CONTROL, 32'h0000_0002, RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    lv(32'h0000_0002);
    wr(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      repeat (32) rs = nx(rs);
      @(posedge sys_clk);
      pins <= rs[31:29];
      tx_busy <= rs[28];
      rx_flow_trigger <= rs[27];
      c = (rs | 32'h0000_0020) & 32'hFFFF_FFFD;
      wr(OFS_CONTROL, c, RESP_OKAY);
      repeat (20) @(posedge sys_clk);
      lv(c);
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      c = {7'h0, i[2:0], 22'h20};
      wr(OFS_CONTROL, c, RESP_OKAY);
      for (int j = 0; j < 6; j++) begin
        repeat (32) rs = nx(rs);
        n = (j < 4) ? lens[j] : {8'h0, rs[7:0]};
        f = {rs[9:8], 1'b0};
        fr(n, f, fx(n, f, c));
      end
    end
    $display("test filter done");
    for (int i = 0; i < 2; i++) begin
      c = {31'h18, i[0]};
      wr(OFS_CONTROL, c, RESP_OKAY);
      fr(16'h0040, 3'h3, fx(16'h0040, 3'h3, c));
      repeat (2) @(posedge sys_clk);
      rd(OFS_STATUS, {27'h0, pins[2:1], 2'h0, c[0]}, RESP_OKAY);
      for (int t = 0; t < 4; t++) begin
        repeat (2) @(posedge sys_clk);
        cmp("hold", {31'h0, c[0] & (t < 3)}, {31'h0, tx_hold_new_r});
        pause_quantum_tick <= 1'b1;
        @(posedge sys_clk);
        pause_quantum_tick <= 1'b0;
      end
    end
    $display("test pause done");
    wr(OFS_CONTROL, 32'h0000_0060, RESP_OKAY);
    tx_coll_defer <= 1'b1;
    @(posedge sys_clk);
    tx_coll_defer <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      repeat (3) @(posedge sys_clk);
      cmp("ipg", {29'h0, (i < 31) ? PACE_IPG_SLOW : PACE_IPG_NORMAL},
          {29'h0, tx_ipg_count_r});
      tx_good_done <= 1'b1;
      @(posedge sys_clk);
      tx_good_done <= 1'b0;
    end
    $display("test pacing done");
    wr(OFS_SOFT_RESET, 32'hFFFF_FFFF, RESP_OKAY);
    fr(16'h0064, 3'h0, 9'h0);
    cmp("iface reset", 32'h1, {31'h0, iface_reset_r});
    repeat (10) @(posedge sys_clk);
    rd(OFS_SOFT_RESET, 32'h0, RESP_OKAY);
    fr(16'h0064, 3'h0, fx(16'h0064, 3'h0, 32'h60));
    repeat (4) @(posedge sys_clk);
    $display("test soft reset done");
    end_sim();
  end
endmodule

// *** inc/ecs_pkg.sv ***
package ecs_pkg;
  // Register bus geometry.
  localparam int AXI_AW = 4;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets.
  localparam logic [AXI_AW-1:0] OFS_CONTROL = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_SOFT_RESET = 4'h8;
  localparam logic [AXI_AW-1:0] OFS_MAX_LEN = 4'hC;
  // Control register fields.
  localparam int CB_COPY_CTRL = 24;
  localparam int CB_COPY_SHORT = 23;
  localparam int CB_COPY_ERR = 22;
  localparam int CB_EXT_MODE = 18;
  localparam int CB_SPEED_FORCE = 17;
  localparam int CB_INTERFACE_CONTROL_OUT_B = 16;
  localparam int CB_INTERFACE_CONTROL_OUT_A = 15;
  localparam int CB_CMD_IDLE = 11;
  localparam int CB_SHORT_GAP = 10;
  localparam int CB_GIG = 7;
  localparam int CB_PACE = 6;
  localparam int CB_IF_EN = 5;
  localparam int CB_TX_FLOW = 4;
  localparam int CB_RX_FLOW = 3;
  localparam int CB_MTEST = 2;
  localparam int CB_LOOPBACK = 1;
  localparam int CB_FULL_DUPLEX = 0;
  // Writable control bits; all others are reserved and read zero.
  localparam logic [31:0] CONTROL_MASK = 32'h01C7_8CFF;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // Status register fields.
  localparam int SB_IDLE = 31;
  localparam int SB_EXTERNAL_SPEED_STATUS = 4;
  localparam int SB_EXT_DUPLEX = 3;
  localparam int SB_RX_FLOW = 1;
  localparam int SB_PAUSE = 0;
  // Receive length checking.
  localparam int MAXLEN_W = 11;
  localparam logic [MAXLEN_W-1:0] MAXLEN_RESET = 11'h5EE;
  localparam int FLEN_W = 16;
  localparam logic [FLEN_W-1:0] MIN_FRAME_LEN = 16'h0040;
  // Transmit pacing.
  localparam int PACE_W = 5;
  localparam logic [PACE_W-1:0] PACE_LOAD = 5'h1F;
  localparam logic [2:0] PACE_IPG_SLOW = 3'h4;
  localparam logic [2:0] PACE_IPG_NORMAL = 3'h1;
  // Soft reset: held-cycle count at which the bit clears; the MAC logic is held one cycle more.
  localparam int SRST_W = 3;
  localparam logic [SRST_W-1:0] SRST_CYCLES = 3'h4;
  // Pause timer width, in pause quanta.
  localparam int PQ_W = 16;
endpackage

// *** rtl/ecs_mac_ctrl.sv ***
`timescale 1ns/1ps
module ecs_mac_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite slave.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ecs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [ecs_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ecs_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ecs_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pins from the PHY side, asynchronous.
  input wire logic ext_speed_in,
  input wire logic ext_duplex_in,
  input wire logic short_gap_in,
  // Events from the MAC datapath, same clock.
  input wire logic rx_frame_done,
  input wire logic [ecs_pkg::FLEN_W-1:0] rx_frame_len,
  input wire logic rx_frame_err,
  input wire logic rx_frame_ctrl,
  input wire logic rx_frame_pause,
  input wire logic [ecs_pkg::PQ_W-1:0] rx_pause_quanta,
  input wire logic pause_quantum_tick,
  input wire logic rx_flow_trigger,
  input wire logic tx_busy,
  input wire logic tx_good_done,
  input wire logic tx_coll_defer,
  // Outputs, all registered.
  output logic rx_keep_r,
  output logic rx_drop_r,
  output logic rx_desc_ctrl_r,
  output logic rx_desc_frag_r,
  output logic rx_desc_under_r,
  output logic rx_desc_over_r,
  output logic rx_desc_jabber_r,
  output logic rx_desc_err_r,
  output logic rx_ctrl_act_r,
  output logic gig_mode_r,
  output logic duplex_mode_r,
  output logic duplex_out_r,
  output logic interface_control_out_a_r,
  output logic interface_control_out_b_r,
  output logic tx_short_gap_r,
  output logic iface_reset_r,
  output logic test_write_en_r,
  output logic loopback_r,
  output logic force_coll_r,
  output logic send_pause_r,
  output logic tx_hold_new_r,
  output logic [2:0] tx_ipg_count_r,
  output logic mac_idle_r
);
  import ecs_pkg::*;

  logic [31:0] ctrl_r; // Control register, reserved bits kept zero.
  logic [MAXLEN_W-1:0] maxlen_r; // Receive maximum frame length.
  logic soft_pend_r; // Soft reset requested and not yet complete.
  logic [SRST_W-1:0] srst_cnt_r; // Cycles the MAC logic has been held.
  logic [PACE_W-1:0] pace_cnt_r; // Pacing counter.
  logic [PQ_W-1:0] pause_cnt_r; // Remaining pause quanta.
  logic [2:0] pins_s; // Synchronised pins: speed, duplex, short gap.
  logic external_speed_status_s;
  logic ext_dup_s;
  logic short_gap_s;
  logic aw_held_r; // Write address taken, waiting for data.
  logic w_held_r; // Write data taken, waiting for address.
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write; // Both halves present, commit this cycle.
  logic [31:0] wmask; // Byte enables widened to bits.
  logic [31:0] status_w; // Live status word.
  logic mac_hold; // MAC logic held in reset.
  logic gig_sel; // Resolved gigabit selection.
  logic full_sel; // Resolved internal full duplex.
  logic is_short;
  logic is_long;
  logic pause_act; // A received pause frame is acted upon.
  logic receive_flow_active; // Receive flow enabled and triggered.

  // Pins cross into this clock before any logic looks at them.
  ecs_sync2 #(.W(3)) ecs_sync2_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({ext_speed_in, ext_duplex_in, short_gap_in}),
    .sync_out(pins_s)
  );
  assign external_speed_status_s = pins_s[2];
  assign ext_dup_s = pins_s[1];
  assign short_gap_s = pins_s[0];

  // Mode resolution: external pins or register bits, then forcing terms.
  always_comb begin
    if (ctrl_r[CB_EXT_MODE]) begin
      gig_sel = external_speed_status_s;
      full_sel = ext_dup_s;
    end else begin
      gig_sel = ctrl_r[CB_GIG];
      full_sel = ctrl_r[CB_FULL_DUPLEX];
    end
    gig_sel = gig_sel | ctrl_r[CB_SPEED_FORCE];
    // Gigabit is full duplex only, and loopback runs full internally.
    full_sel = full_sel | gig_sel | ctrl_r[CB_LOOPBACK];
  end

  assign mac_hold = ~ctrl_r[CB_IF_EN] | soft_pend_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign receive_flow_active = ctrl_r[CB_RX_FLOW] & rx_flow_trigger;
  assign is_short = rx_frame_len < MIN_FRAME_LEN;
  assign is_long = rx_frame_len > {5'h00, maxlen_r};
  // Pause frames act regardless of the copy-control bit.
  assign pause_act = rx_frame_done & rx_frame_pause & ~mac_hold & duplex_mode_r
    & ctrl_r[CB_TX_FLOW];

  // Reserved positions are hard zero, so reads return zero for them.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[SB_IDLE] = mac_idle_r;
    status_w[SB_EXTERNAL_SPEED_STATUS] = external_speed_status_s;
    status_w[SB_EXT_DUPLEX] = ext_dup_s;
    status_w[SB_RX_FLOW] = receive_flow_active;
    status_w[SB_PAUSE] = tx_hold_new_r;
  end

  // Write channel: address and data are taken independently and held.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Ready is withheld while a half is held or a response is pending.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
    end
  end

  // Write response: unmapped or read-only offsets answer with an error.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r == OFS_CONTROL || awaddr_r == OFS_SOFT_RESET || awaddr_r == OFS_MAX_LEN) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and length registers; reserved bits never store.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= CONTROL_RESET;
      maxlen_r <= MAXLEN_RESET;
    end else if (do_write) begin
      if (awaddr_r == OFS_CONTROL) begin
        ctrl_r <= ((ctrl_r & ~wmask) | (wdata_r & wmask)) & CONTROL_MASK;
      end
      if (awaddr_r == OFS_MAX_LEN) begin
        maxlen_r <= (maxlen_r & ~wmask[MAXLEN_W-1:0])
          | (wdata_r[MAXLEN_W-1:0] & wmask[MAXLEN_W-1:0]);
      end
    end
  end

  // Soft reset: a written one is held while the MAC logic is reset,
  // then clears so software can poll. A new write wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_pend_r <= 1'b0;
      srst_cnt_r <= '0;
    end else if (do_write && awaddr_r == OFS_SOFT_RESET && wstrb_r[0] && wdata_r[0]) begin
      soft_pend_r <= 1'b1;
      srst_cnt_r <= '0;
    end else if (soft_pend_r) begin
      if (srst_cnt_r == SRST_CYCLES) begin
        soft_pend_r <= 1'b0;
      end else begin
        srst_cnt_r <= srst_cnt_r + 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CONTROL: s_axi_rdata <= ctrl_r;
        OFS_STATUS: s_axi_rdata <= status_w;
        OFS_SOFT_RESET: s_axi_rdata <= {31'h0000_0000, soft_pend_r};
        OFS_MAX_LEN: s_axi_rdata <= {21'h00_0000, maxlen_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Static mode and pin outputs follow the resolved modes and the control bits.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gig_mode_r <= 1'b0;
      duplex_mode_r <= 1'b0;
      duplex_out_r <= 1'b0;
      interface_control_out_a_r <= 1'b0;
      interface_control_out_b_r <= 1'b0;
      tx_short_gap_r <= 1'b0;
      iface_reset_r <= 1'b1;
      test_write_en_r <= 1'b0;
      loopback_r <= 1'b0;
    end else begin
      gig_mode_r <= gig_sel;
      duplex_mode_r <= full_sel;
      duplex_out_r <= ctrl_r[CB_FULL_DUPLEX];
      interface_control_out_a_r <= ctrl_r[CB_INTERFACE_CONTROL_OUT_A];
      interface_control_out_b_r <= ctrl_r[CB_INTERFACE_CONTROL_OUT_B];
      tx_short_gap_r <= ctrl_r[CB_SHORT_GAP] & short_gap_s;
      iface_reset_r <= mac_hold;
      test_write_en_r <= ctrl_r[CB_MTEST];
      // Software is expected to flip loopback only while disabled.
      loopback_r <= ctrl_r[CB_LOOPBACK];
    end
  end

  // Receive frame filter. Drop wins if any class is not enabled for copy.
  always_ff @(posedge sys_clk) begin
    if (srst || mac_hold) begin
      rx_keep_r <= 1'b0;
      rx_drop_r <= 1'b0;
      rx_desc_ctrl_r <= 1'b0;
      rx_desc_frag_r <= 1'b0;
      rx_desc_under_r <= 1'b0;
      rx_desc_over_r <= 1'b0;
      rx_desc_jabber_r <= 1'b0;
      rx_desc_err_r <= 1'b0;
      rx_ctrl_act_r <= 1'b0;
    end else begin
      rx_drop_r <= rx_frame_done & ((rx_frame_ctrl & ~ctrl_r[CB_COPY_CTRL])
        | (is_short & ~ctrl_r[CB_COPY_SHORT])
        | (rx_frame_err & ~ctrl_r[CB_COPY_ERR]));
      rx_keep_r <= rx_frame_done & ~((rx_frame_ctrl & ~ctrl_r[CB_COPY_CTRL])
        | (is_short & ~ctrl_r[CB_COPY_SHORT]) | (rx_frame_err & ~ctrl_r[CB_COPY_ERR]));
      rx_desc_ctrl_r <= rx_frame_done & rx_frame_ctrl;
      rx_desc_frag_r <= rx_frame_done & is_short & rx_frame_err;
      rx_desc_under_r <= rx_frame_done & is_short & ~rx_frame_err;
      rx_desc_over_r <= rx_frame_done & is_long & ~rx_frame_err;
      rx_desc_jabber_r <= rx_frame_done & is_long & rx_frame_err;
      rx_desc_err_r <= rx_frame_done & rx_frame_err;
      // Non-pause control frames are acted upon whether copied or not.
      rx_ctrl_act_r <= rx_frame_done & rx_frame_ctrl & ~rx_frame_pause;
    end
  end

  // Pause timer: loaded by an accepted pause frame, counts down per quantum.
  always_ff @(posedge sys_clk) begin
    if (srst || mac_hold) begin
      pause_cnt_r <= '0;
      tx_hold_new_r <= 1'b0;
    end else begin
      if (pause_act) begin
        pause_cnt_r <= rx_pause_quanta;
        tx_hold_new_r <= rx_pause_quanta != '0;
      end else if (pause_quantum_tick && pause_cnt_r != '0) begin
        pause_cnt_r <= pause_cnt_r - 1'b1;
        tx_hold_new_r <= pause_cnt_r != {{(PQ_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Receive flow control reaction depends on the duplex in use.
  always_ff @(posedge sys_clk) begin
    if (srst || mac_hold) begin
      force_coll_r <= 1'b0;
      send_pause_r <= 1'b0;
    end else begin
      force_coll_r <= receive_flow_active & ~duplex_mode_r;
      send_pause_r <= receive_flow_active & duplex_mode_r;
    end
  end

  // Transmit pacing reduces capture effect; disabled pacing keeps zero.
  always_ff @(posedge sys_clk) begin
    if (srst || mac_hold || !ctrl_r[CB_PACE]) begin
      pace_cnt_r <= '0;
    end else if (tx_coll_defer) begin
      pace_cnt_r <= PACE_LOAD;
    end else if (tx_good_done && pace_cnt_r != '0) begin
      pace_cnt_r <= pace_cnt_r - 1'b1;
    end
  end

  // Gap multiplier seen by the transmitter.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_ipg_count_r <= PACE_IPG_NORMAL;
    end else begin
      tx_ipg_count_r <= (pace_cnt_r != '0) ? PACE_IPG_SLOW : PACE_IPG_NORMAL;
    end
  end

  // Idle is entered once commanded and no transmission is running.
  always_ff @(posedge sys_clk) begin
    if (srst || mac_hold) begin
      mac_idle_r <= 1'b0;
    end else begin
      mac_idle_r <= ctrl_r[CB_CMD_IDLE] & ~tx_busy;
    end
  end

  // Checks on the block's own outputs and internal state.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence soft_start_s;
    $rose(soft_pend_r);
  endsequence
  // The interface reset output lags the pending bit by one register stage.
  sequence soft_done_s;
    !soft_pend_r;
  endsequence

  soft_reset_clear_a: assert property (soft_start_s |=> iface_reset_r
    ##[1:8] soft_done_s)
    else $error("Soft reset bit did not clear in time.");
  gig_full_a: assert property (gig_mode_r |-> duplex_mode_r)
    else $error("Gigabit mode without full duplex.");
  loop_full_a: assert property (ctrl_r[CB_LOOPBACK] && $stable(ctrl_r) |=> duplex_mode_r)
    else $error("Loopback did not force full duplex.");
  iface_hold_a: assert property (!ctrl_r[CB_IF_EN] |=> iface_reset_r)
    else $error("Interface not held in reset.");
  short_drop_a: assert property (rx_frame_done && is_short && !ctrl_r[CB_COPY_SHORT]
    && !mac_hold |=> rx_drop_r && !rx_keep_r)
    else $error("Short frame not filtered.");
  pause_half_a: assert property (!duplex_mode_r && !tx_hold_new_r && !mac_hold
    |=> !tx_hold_new_r)
    else $error("Pause acted upon in half duplex.");
  pace_load_a: assert property (tx_coll_defer && ctrl_r[CB_PACE] && !mac_hold
    |=> pace_cnt_r == 5'h1F ##1 tx_ipg_count_r == 3'h4)
    else $error("Pacing counter not loaded with 31.");
  flow_coll_a: assert property (receive_flow_active && !duplex_mode_r && !mac_hold
    |=> force_coll_r && !send_pause_r)
    else $error("Receive flow did not force collision.");
  long_jabber_a: assert property (rx_frame_done && is_long && rx_frame_err && !mac_hold
    |=> rx_desc_jabber_r && !rx_desc_over_r)
    else $error("Long errored frame not marked jabber.");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken.");
endmodule

// *** rtl/ecs_sync2.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a group of independent level inputs.
// Only the second stage may be read by downstream logic.
module ecs_sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r; // First stage, may go metastable.

  // Both stages reset low so status reads zero until real samples arrive.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
